// *** rtl/psl_clkdiv.sv ***
// strobe generator for the mii clock rate
`timescale 1ns/1ps
module psl_clkdiv #(
  parameter int unsigned DIV_SLOW = psl_pkg::MII10_DIV
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic fast_i,
  output logic      tick_o
);
  localparam int unsigned CW = $clog2(DIV_SLOW);
  localparam logic [CW-1:0] LAST = CW'(DIV_SLOW - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } psl_div_st_t;

  psl_div_st_t st_q;
  psl_div_st_t st_d;

  always_comb begin
    st_d = st_q;
    if (fast_i) begin
      st_d.cnt  = '0;
      st_d.tick = 1'b1;
    end else if (st_q.cnt == LAST) begin
      st_d.cnt  = '0;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt  = st_q.cnt + 1'b1;
      st_d.tick = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick_o = st_q.tick;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_slow_tick_gap : assert property (
    (tick_o && !fast_i) ##1 !fast_i [*8] |-> !tick_o ##1 !tick_o ##1 tick_o)
    else $error("slow mii strobe came early");
endmodule : psl_clkdiv

// *** rtl/psl_pkg.sv ***
// constants, carriers and helpers shared by the pin control block
package psl_pkg;

  // ****************************************************************
  // clocking and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned MII10_HZ      = 2_500_000;
  localparam int unsigned MII100_HZ     = 25_000_000;
  localparam int unsigned MII10_DIV     = CLK_HZ / MII10_HZ;
  localparam int unsigned MII100_DIV    = CLK_HZ / MII100_HZ;

  // least times round up, never below one cycle
  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    ns_to_cyc = (c == 0) ? 1 : c;
  endfunction : ns_to_cyc

  localparam int unsigned POR_NS       = 1000;
  localparam int unsigned POR_CYC      = ns_to_cyc(POR_NS);
  localparam int unsigned ACT_HOLD_NS  = 40960;
  localparam int unsigned ACT_HOLD_CYC = ns_to_cyc(ACT_HOLD_NS);
  localparam int unsigned ACT_W        = 11;
  localparam int unsigned BLINK_BIT    = 7;
  localparam int unsigned POR_W        = 6;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam logic [7:0] ADDR_CTRL  = 8'h18;
  localparam logic [7:0] ADDR_ISTAT = 8'h1A;
  localparam logic [7:0] ADDR_IMASK = 8'h1B;
  localparam logic [7:0] ADDR_PINS  = 8'h1C;

  localparam int unsigned CTRL_SYM_BIT = 0;
  localparam int unsigned CTRL_POL_BIT = 12;
  localparam logic [15:0] CTRL_RST     = 16'h0000;

  localparam int unsigned IRQ_W        = 2;
  localparam int unsigned IRQ_LINK_BIT = 0;
  localparam int unsigned IRQ_XRST_BIT = 1;
  localparam logic [1:0]  IMASK_RST    = 2'h0;

  // synchronised pin vector layout
  localparam int unsigned PIN_N    = 7;
  localparam int unsigned PIN_LINE = 0;
  localparam int unsigned PIN_FD   = 1;
  localparam int unsigned PIN_SPD  = 2;
  localparam int unsigned PIN_IRQ_PIN_SELECT = 3;
  localparam int unsigned PIN_AN   = 4;
  localparam int unsigned PIN_RECEIVE_ENABLE_PIN = 5;
  localparam int unsigned PIN_RPT  = 6;
  localparam logic [6:0]  PIN_RST  = 7'h00;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic o;
    logic oe;
  } psl_pin_t;

endpackage : psl_pkg

// *** rtl/psl_sync.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module psl_sync #(
  parameter int unsigned     W       = 1,
  parameter logic [W-1:0]    RST_VAL = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } psl_sync_st_t;

  psl_sync_st_t st_q;
  psl_sync_st_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = d_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // a bit changes only once stages two and three agree
    for (int i = 0; i < W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.q[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign q_o = st_q.q;
endmodule : psl_sync

// *** rtl/psl_top.sv ***
// strap, led, interrupt and enable pin logic of the phy
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps

module psl_top (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic [7:0]           reg_addr_i,
  input  wire logic [15:0]          reg_wdata_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  output logic      [15:0]          reg_rdata_o,
  output logic                      irq_o,
  input  wire logic                 reset_line_i,
  output psl_pkg::psl_pin_t         reset_line_o,
  input  wire logic                 duplex_led_strap_i,
  output psl_pkg::psl_pin_t         duplex_led_strap_o,
  input  wire logic                 speed_led_strap_i,
  output psl_pkg::psl_pin_t         speed_led_strap_o,
  input  wire logic                 irq_pin_select_i,
  input  wire logic                 autoneg_strap_i,
  input  wire logic                 receive_enable_pin_i,
  input  wire logic                 repeater_select_i,
  output logic                      activity_led_o,
  output logic                      collision_led_o,
  output logic                      link_led_o,
  input  wire logic                 link_up_i,
  input  wire logic                 speed_100_i,
  input  wire logic                 full_duplex_i,
  input  wire logic                 activity_i,
  input  wire logic                 carrier_i,
  input  wire logic                 collision_i,
  input  wire logic                 tx_err_pin_i,
  input  wire logic                 rx_err_i,
  input  wire logic                 rx_symbol_bit4_i,
  output logic                      crs_o,
  output logic                      col_o,
  output logic                      tx_err_o,
  output logic                      tx_symbol_bit4_o,
  output logic                      rx_err_pin_o,
  output logic                      mii_clk_en_o,
  output logic                      core_reset_o,
  output logic                      adv_full_duplex_o,
  output logic                      adv_100_o,
  output logic                      autoneg_en_o,
  output logic                      rx_enable_o,
  output logic                      repeater_en_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [15:0]                ctrl;
    logic [1:0]                 istat;
    logic [1:0]                 imask;
    logic [15:0]                rdata;
    logic                       irq;
    logic [psl_pkg::POR_W-1:0]  por_cnt;
    logic                       por_drv;
    logic                       line;
    logic                       adv_fd;
    logic                       adv_100;
    logic                       link;
    logic [psl_pkg::ACT_W-1:0]  act_cnt;
    psl_pkg::psl_pin_t          rst_pin;
    psl_pkg::psl_pin_t          fd_pin;
    psl_pkg::psl_pin_t          spd_pin;
    logic                       act_led;
    logic                       col_led;
    logic                       lnk_led;
    logic                       core_rst;
    logic                       an_en;
    logic                       rx_en;
    logic                       rpt_en;
    logic                       crs;
    logic                       col;
    logic                       tx_err;
    logic                       tx_sym4;
    logic                       rx_err;
  } psl_top_st_t;

  psl_top_st_t st_q;
  psl_top_st_t st_d;

  logic [psl_pkg::PIN_N-1:0] pin_s;
  logic                      line_low;
  logic                      mgmt_interrupt_lvl;
  logic                      act_on;
  logic [1:0]                ev;

  // ****************************************************************
  // pin synchronisers and mii strobe
  // ****************************************************************
  psl_sync #(
    .W       (psl_pkg::PIN_N),
    .RST_VAL (psl_pkg::PIN_RST)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({repeater_select_i, receive_enable_pin_i, autoneg_strap_i,
             irq_pin_select_i, speed_led_strap_i, duplex_led_strap_i,
             reset_line_i}),
    .q_o   (pin_s)
  );

  // strobe rate follows the resolved speed of the core
  psl_clkdiv #(
    .DIV_SLOW (psl_pkg::MII10_DIV)
  ) u_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .fast_i (speed_100_i),
    .tick_o (mii_clk_en_o)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  // our own drive is counted as low at once; the pin echo lags
  assign line_low = !pin_s[psl_pkg::PIN_LINE] || st_q.por_drv;
  assign act_on   = (st_q.act_cnt != '0);

  always_comb begin
    st_d     = st_q;
    ev       = '0;
    mgmt_interrupt_lvl = 1'b0;

    // power-on drive of the open-drain reset line
    if (st_q.por_drv) begin
      if (st_q.por_cnt == psl_pkg::POR_W'(psl_pkg::POR_CYC - 1)) begin
        st_d.por_drv = 1'b0;
      end else begin
        st_d.por_cnt = st_q.por_cnt + 1'b1;
      end
    end
    st_d.rst_pin.o  = 1'b0;
    st_d.rst_pin.oe = st_d.por_drv;

    // external low while we are not driving is a reset request
    st_d.line = pin_s[psl_pkg::PIN_LINE];
    if (!pin_s[psl_pkg::PIN_LINE] && st_q.line && !st_q.por_drv) begin
      ev[psl_pkg::IRQ_XRST_BIT] = 1'b1;
    end
    st_d.core_rst = line_low;

    // straps are caught on the rising edge of the line
    if (pin_s[psl_pkg::PIN_LINE] && !st_q.line) begin
      st_d.adv_fd  = pin_s[psl_pkg::PIN_FD];
      st_d.adv_100 = !pin_s[psl_pkg::PIN_SPD];
    end

    // strap pins are inputs while the line is low
    if (line_low) begin
      st_d.fd_pin  = '{o: 1'b1, oe: 1'b0};
      st_d.spd_pin = '{o: 1'b1, oe: 1'b0};
    end else begin
      st_d.fd_pin  = '{o: !full_duplex_i, oe: 1'b1};
      st_d.spd_pin = '{o: speed_100_i, oe: 1'b1};
    end

    // link change only counts once the line is up
    st_d.link = link_up_i;
    if (!line_low && (link_up_i != st_q.link)) begin
      ev[psl_pkg::IRQ_LINK_BIT] = 1'b1;
    end

    // activity stretch so a single frame is visible
    if (activity_i) begin
      st_d.act_cnt = psl_pkg::ACT_W'(psl_pkg::ACT_HOLD_CYC - 1);
    end else if (act_on) begin
      st_d.act_cnt = st_q.act_cnt - 1'b1;
    end

    // register writes; status is write-one-to-clear, set wins
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        psl_pkg::ADDR_CTRL:  st_d.ctrl  = reg_wdata_i;
        psl_pkg::ADDR_IMASK: st_d.imask = reg_wdata_i[1:0];
        psl_pkg::ADDR_ISTAT: st_d.istat = st_q.istat & ~reg_wdata_i[1:0];
        default: ;
      endcase
    end
    st_d.istat = st_d.istat | ev;
    st_d.irq   = |(st_d.istat & st_d.imask);

    // interrupt pin polarity: control bit set means active high
    mgmt_interrupt_lvl = st_d.ctrl[psl_pkg::CTRL_POL_BIT] ? st_d.irq
                                                : !st_d.irq;

    // led and interrupt steering
    if (pin_s[psl_pkg::PIN_IRQ_PIN_SELECT]) begin
      st_d.act_led = !act_on;
      st_d.col_led = mgmt_interrupt_lvl;
      st_d.lnk_led = !link_up_i;
    end else begin
      st_d.act_led = mgmt_interrupt_lvl;
      st_d.col_led = !collision_i;
      // blink off while activity lasts, so link stays readable
      st_d.lnk_led = !(link_up_i &&
                       !(act_on && st_q.act_cnt[psl_pkg::BLINK_BIT]));
    end

    // level enables from the strap pins
    st_d.an_en  = pin_s[psl_pkg::PIN_AN];
    st_d.rx_en  = pin_s[psl_pkg::PIN_RECEIVE_ENABLE_PIN];
    st_d.rpt_en = pin_s[psl_pkg::PIN_RPT];

    st_d.crs = carrier_i;
    st_d.col = collision_i;

    // symbol mode reuses the error lines as the fifth bit
    if (st_d.ctrl[psl_pkg::CTRL_SYM_BIT]) begin
      st_d.tx_err  = 1'b0;
      st_d.tx_sym4 = tx_err_pin_i;
      st_d.rx_err  = rx_symbol_bit4_i;
    end else begin
      st_d.tx_err  = tx_err_pin_i;
      st_d.tx_sym4 = 1'b0;
      st_d.rx_err  = rx_err_i;
    end

    // read data stands only in the cycle after the strobe
    st_d.rdata = '0;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        psl_pkg::ADDR_CTRL:  st_d.rdata = st_q.ctrl;
        psl_pkg::ADDR_ISTAT: st_d.rdata = {14'h0000, st_q.istat};
        psl_pkg::ADDR_IMASK: st_d.rdata = {14'h0000, st_q.imask};
        psl_pkg::ADDR_PINS:  st_d.rdata = {8'h00, st_q.adv_100,
                                           st_q.adv_fd, pin_s[6:3],
                                           st_q.link, line_low};
        default: st_d.rdata = '0;
      endcase
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q          <= '0;
      st_q.ctrl     <= psl_pkg::CTRL_RST;
      st_q.imask    <= psl_pkg::IMASK_RST;
      st_q.por_drv  <= 1'b1;
      st_q.rst_pin  <= '{o: 1'b0, oe: 1'b1};
      st_q.fd_pin   <= '{o: 1'b1, oe: 1'b0};
      st_q.spd_pin  <= '{o: 1'b1, oe: 1'b0};
      st_q.act_led  <= 1'b1;
      st_q.col_led  <= 1'b1;
      st_q.lnk_led  <= 1'b1;
      st_q.core_rst <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata_o        = st_q.rdata;
  assign irq_o              = st_q.irq;
  assign reset_line_o       = st_q.rst_pin;
  assign duplex_led_strap_o = st_q.fd_pin;
  assign speed_led_strap_o  = st_q.spd_pin;
  assign activity_led_o     = st_q.act_led;
  assign collision_led_o    = st_q.col_led;
  assign link_led_o         = st_q.lnk_led;
  assign crs_o              = st_q.crs;
  assign col_o              = st_q.col;
  assign tx_err_o           = st_q.tx_err;
  assign tx_symbol_bit4_o   = st_q.tx_sym4;
  assign rx_err_pin_o       = st_q.rx_err;
  assign core_reset_o       = st_q.core_rst;
  assign adv_full_duplex_o  = st_q.adv_fd;
  assign adv_100_o          = st_q.adv_100;
  assign autoneg_en_o       = st_q.an_en;
  assign rx_enable_o        = st_q.rx_en;
  assign repeater_en_o      = st_q.rpt_en;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_strap_fd_latch : assert property (
    (pin_s[0] && !st_q.line) |=> adv_full_duplex_o == $past(pin_s[1])
      ##1 $stable(adv_full_duplex_o) [*2])
    else $error("duplex strap not latched at line rise");

  a_strap_spd_latch : assert property (
    (pin_s[0] && !st_q.line) |=> adv_100_o == !$past(pin_s[2]))
    else $error("speed strap not latched inverted");

  a_strap_pin_input : assert property (
    line_low |=> !duplex_led_strap_o.oe && !speed_led_strap_o.oe)
    else $error("strap pin driven while line low");

  a_duplex_led : assert property (
    !line_low |=> duplex_led_strap_o.oe &&
                  duplex_led_strap_o.o == !$past(full_duplex_i))
    else $error("duplex led wrong after reset");

  a_speed_led : assert property (
    !line_low |=> speed_led_strap_o.o == $past(speed_100_i))
    else $error("speed led wrong after reset");

  a_irq_pin_steer : assert property (
    pin_s[3] |=> collision_led_o ==
      (st_q.ctrl[12] ? irq_o : !irq_o))
    else $error("collision pin not carrying interrupt");

  a_act_pin_steer : assert property (
    !pin_s[3] |=> activity_led_o == (st_q.ctrl[12] ? irq_o : !irq_o))
    else $error("activity pin not carrying interrupt");

  a_link_irq_set : assert property (
    (!line_low && link_up_i != st_q.link && st_d.imask[0])
      |=> irq_o && st_q.istat[0])
    else $error("link change did not interrupt");

  a_reset_request : assert property (
    !pin_s[0] |=> core_reset_o)
    else $error("line low not seen as reset");

  a_por_release : assert property (
    $fell(st_q.por_drv) |-> !reset_line_o.oe ##1 !st_q.por_drv [*3])
    else $error("power-on drive did not release");

  a_pin_enables : assert property (
    1'b1 |=> autoneg_en_o == $past(pin_s[4]) &&
             rx_enable_o == $past(pin_s[5]) &&
             repeater_en_o == $past(pin_s[6]))
    else $error("enable pins not followed");

  a_crs_col_high : assert property (
    carrier_i && collision_i |=> crs_o && col_o)
    else $error("carrier or collision not active high");

  a_symbol_bits : assert property (
    st_d.ctrl[0] |=> tx_symbol_bit4_o == $past(tx_err_pin_i) &&
                     rx_err_pin_o == $past(rx_symbol_bit4_i) && !tx_err_o)
    else $error("symbol mode bit four wrong");

  c_strap_latch : cover property (pin_s[0] && !st_q.line);
  c_link_irq    : cover property (!irq_o ##1 irq_o);
  c_ext_reset   : cover property (st_q.line && !pin_s[0] && !st_q.por_drv);
  c_link_flash  : cover property (!pin_s[3] && act_on && link_up_i);

endmodule : psl_top

// *** test/psl_mac_model.sv ***
// far-side model: mac and line core driving the block's core inputs
`timescale 1ns/1ps
module psl_mac_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [9:0] cmd_i,
  input  wire logic       mii_clk_en_i,
  output logic      [9:0] core_o,
  output logic      [7:0] ticks_o,
  output logic            mdc_o
);
  logic [2:0] mdc_cnt;

  // ****************************************************************
  // registered drive
  // ****************************************************************
  // bits: 0 link, 1 speed, 2 duplex, 3 activity, 4 carrier, 5 collision,
  // 6 tx error/bit4, 7 rx error, 8 rx bit4, 9 pulls the reset wire low
  // outputs move only after an edge, as a real mac would launch them
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      core_o  <= 10'h000;
      ticks_o <= 8'h00;
    end else begin
      core_o  <= cmd_i;
      // free-running count of mii clock periods seen
      ticks_o <= ticks_o + {7'h00, mii_clk_en_i};
    end
  end

  // management clock at a tenth of the core clock, its fastest legal rate
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mdc_cnt <= 3'h0;
      mdc_o   <= 1'b0;
    end else if (mdc_cnt == 3'h4) begin
      mdc_cnt <= 3'h0;
      mdc_o   <= ~mdc_o;
    end else begin
      mdc_cnt <= mdc_cnt + 3'h1;
    end
  end
endmodule : psl_mac_model

// *** test/tb_top.sv ***
// self-checking bench for the strap, led and interrupt pin block
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
  miscompares++; $display("BAD t=%0t got=%0h exp=%0h", $time, g, e); \
  end end
module tb_top;
  logic              clk_i, rst_i, reg_wr, reg_rd, sel, an, receive_enable_pin, rpt;
  logic              fd_pin, spd_pin, line, fd_strap, sp_strap;
  logic [7:0]        addr, ticks;
  logic [15:0]       wdata, rdata, rv;
  logic [9:0]        cmd, core;
  psl_pkg::psl_pin_t rl_o, fd_o, sp_o;
  logic              irq, act_led, col_led, lnk_led, crs, col, txe, txs;
  logic              rxe, mclk, core_rst, adv_fd, adv_100, an_en, rx_en;
  logic              rp_en;
  int                miscompares, comparisons, n;
  // inputs {sel,an,receive_enable_pin,rpt,fd,spd,car,col} beside expected
  // {crs,col,an_en,rx_en,rp_en,duplex pin,speed pin,collision led}
  localparam logic [15:0] rows [4] = '{16'h0005, 16'hDAA9, 16'h2556,
                                       16'hFFFB};

  // ****************************************************************
  // wires: open-drain reset line with pull-up, strap resistors
  // ****************************************************************
  assign line    = (rl_o.oe ? rl_o.o : 1'b1) & ~core[9];
  assign fd_pin  = fd_o.oe ? fd_o.o : fd_strap;
  assign spd_pin = sp_o.oe ? sp_o.o : sp_strap;

  psl_top u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .irq_o(irq),
    .reset_line_i(line), .reset_line_o(rl_o),
    .duplex_led_strap_i(fd_pin), .duplex_led_strap_o(fd_o),
    .speed_led_strap_i(spd_pin), .speed_led_strap_o(sp_o),
    .irq_pin_select_i(sel), .autoneg_strap_i(an),
    .receive_enable_pin_i(receive_enable_pin), .repeater_select_i(rpt),
    .activity_led_o(act_led), .collision_led_o(col_led),
    .link_led_o(lnk_led), .link_up_i(core[0]), .speed_100_i(core[1]),
    .full_duplex_i(core[2]), .activity_i(core[3]), .carrier_i(core[4]),
    .collision_i(core[5]), .tx_err_pin_i(core[6]), .rx_err_i(core[7]),
    .rx_symbol_bit4_i(core[8]), .crs_o(crs), .col_o(col), .tx_err_o(txe),
    .tx_symbol_bit4_o(txs), .rx_err_pin_o(rxe), .mii_clk_en_o(mclk),
    .core_reset_o(core_rst), .adv_full_duplex_o(adv_fd),
    .adv_100_o(adv_100), .autoneg_en_o(an_en), .rx_enable_o(rx_en),
    .repeater_en_o(rp_en));

  psl_mac_model u_mac (
    .clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd), .mii_clk_en_i(mclk),
    .core_o(core), .ticks_o(ticks), .mdc_o());

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic end_sim;
    if (miscompares == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  task automatic settle(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : settle

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr   <= a;
    wdata  <= d;
    reg_wr <= 1'b1;
    @(posedge clk_i);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr   <= a;
    reg_rd <= 1'b1;
    @(posedge clk_i);
    reg_rd <= 1'b0;
    #1 d = rdata;
  endtask : rd

  // bounded wait for the core to leave reset; lo is the least hold
  task automatic wait_boot(input int lo);
    n = 0;
    while (core_rst !== 1'b0 && n < 100) begin
      settle(1);
      n++;
    end
    if (n >= 100) begin
      miscompares++;
      end_sim();
    end else begin
      `CHK(n >= lo, 1'b1)
    end
  endtask : wait_boot

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rst_i = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; addr = 8'h00;
    wdata = 16'h0000; cmd = 10'h000; sel = 1'b0; an = 1'b0; receive_enable_pin = 1'b0;
    rpt = 1'b0; fd_strap = 1'b1; sp_strap = 1'b0;
    miscompares = 0; comparisons = 0;
    repeat (20) @(posedge clk_i);
    #1;
    `CHK({rl_o.oe, fd_o.oe, sp_o.oe, core_rst}, 4'h9)
    @(posedge clk_i);
    rst_i <= 1'b0;
    wait_boot(25);
    settle(2);
    `CHK({adv_fd, adv_100, fd_o.oe, sp_o.oe}, 4'hF)
    rd(8'h1C, rv);
    `CHK(rv, 16'h00C0)
    rd(8'h18, rv);
    `CHK(rv, 16'h0000)
    rd(8'h00, rv);
    `CHK(rv, 16'h0000)
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      {sel, an, receive_enable_pin, rpt} <= rows[i][15:12];
      cmd <= {4'h0, rows[i][8], rows[i][9], 1'b0, rows[i][11],
              rows[i][10], 1'b0};
      settle(8);
      rv[7:0] = {crs, col, an_en, rx_en, rp_en, fd_o.o, sp_o.o, col_led};
      `CHK(rv[7:5], rows[i][7:5])
      `CHK(rv[4:0], rows[i][4:0])
    end
    for (int s = 1; s >= 0; s--) begin
      @(posedge clk_i);
      cmd <= {8'h00, s[0], 1'b0};
      settle(10);
      rv[7:0] = ticks;
      settle(100);
      `CHK(8'(ticks - rv[7:0]), (s == 1) ? 8'h64 : 8'h0A)
    end
    // link change with the interrupt routed to each pin in turn
    wr(8'h1B, 16'h0001);
    rd(8'h1B, rv);
    `CHK(rv, 16'h0001)
    @(posedge clk_i);
    cmd[0] <= 1'b1;
    sel    <= 1'b1;
    settle(8);
    `CHK({irq, col_led}, 2'h2)
    @(posedge clk_i);
    sel <= 1'b0;
    settle(8);
    `CHK(act_led, 1'b0)
    wr(8'h18, 16'h1000);
    settle(2);
    `CHK(act_led, 1'b1)
    rd(8'h1A, rv);
    `CHK(rv[0], 1'b1)
    wr(8'h1A, 16'h0001);
    settle(2);
    `CHK(irq, 1'b0)
    // activity flashes the link led while the interrupt owns its pin
    `CHK(lnk_led, 1'b0)
    @(posedge clk_i);
    cmd[3] <= 1'b1;
    @(posedge clk_i);
    cmd[3] <= 1'b0;
    n = 0;
    while (lnk_led !== 1'b1 && n < 600) begin
      settle(1);
      n++;
    end
    if (n >= 600) begin
      miscompares++;
      end_sim();
    end
    `CHK(lnk_led, 1'b1)
    settle(130);
    `CHK(lnk_led, 1'b0)
    @(posedge clk_i);
    sel <= 1'b1;
    settle(8);
    `CHK(act_led, 1'b0)
    @(posedge clk_i);
    cmd[8:6] <= 3'h5;
    settle(4);
    `CHK({txe, txs, rxe}, 3'h4)
    wr(8'h18, 16'h0001);
    settle(2);
    `CHK({txe, txs, rxe}, 3'h3)
    // external reset request latches the opposite strap levels
    @(posedge clk_i);
    fd_strap <= 1'b0;
    sp_strap <= 1'b1;
    cmd[9]   <= 1'b1;
    settle(8);
    `CHK({fd_o.oe, sp_o.oe, core_rst}, 3'h1)
    rd(8'h1A, rv);
    `CHK(rv[1], 1'b1)
    @(posedge clk_i);
    cmd[9] <= 1'b0;
    wait_boot(4);
    settle(2);
    `CHK({adv_fd, adv_100}, 2'h0)
    rd(8'h1C, rv);
    `CHK(rv, 16'h003E)
    end_sim();
  end
endmodule : tb_top
